//--- logic/cmo_can_port_link.sv
// Message-object register file, AXI4-Lite slave and pin routing of the CAN port link
`timescale 1ns/10ps
//
// Contract
// R1: Each control flag is a bit pair; 10 means set, 01 means reset.
// R2: Remote frame to transmit object sets remote pending and transmit request.
// R3: CPU clears update-in-progress and sets fresh data after a partial update.
// R4: Remote request answered only when update clear and fresh data set.
// R5: CPU sets transmit request only for active sending, else leaves it.
// R6: Stored data frame sets fresh data, irq pending; irq if receive enabled.
// R7: CPU clears irq pending and fresh data, reads, rechecks fresh data.
// R8: CPU sets transmit request of a receive object to send remote frame.
// R9: Receive object transmit request cleared on remote sent or data arrival.
// R10: Receive objects use pair 11-10 as message lost indicator.
// R11: Logic 0 is dominant, logic 1 recessive on receive and transmit.
// R12: Code 010 routes to first pin pair, 011 to second pin pair.
// R13: Software never writes reserved pin codes 000, 001, 100, 101, 110.
// R14: Code 111, the reset value, disconnects transmit and idles receive recessive.
// R15: Assigned transmit pin driver enabled regardless of port direction.
// R16: Software sets the receive pin direction to input.
// R17: Assigned pins override any other alternate function on them.
// R18: While init flag set, no transfers and transmit line held recessive.
module cmo_can_port_link
	import cmo_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic rx_frame_i,
	input wire logic rx_remote_i,
	input wire logic [1:0] rx_obj_i,
	input wire logic tx_done_i,
	input wire logic [1:0] tx_done_obj_i,
	input wire logic bus_transmit_line_i,
	output logic bus_receive_line_o,
	output logic tx_request_o,
	output logic [1:0] tx_obj_o,
	output logic tx_remote_o,
	output logic init_o,
	input wire logic [3:0] port_dir_i,
	input wire logic [3:0] alt_out_i,
	input wire logic [3:0] pin_in_i,
	output logic [3:0] pin_out_o,
	output logic [3:0] pin_oe_n_o,
	output logic irq_o
);

	// ==========================================================
	// Bus slave state
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_full_q, w_full_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// ==========================================================
	// Block registers
	logic [NUM_OBJ-1:0] dir_q;
	logic [2:0] psel_q;
	logic init_q;
	logic [2*NUM_OBJ-1:0] stat_q, mask_q;
	logic [PIN_W-1:0] pin_s1_q, pin_s2_q, pin_out_q, pin_oe_n_q;
	logic rx_line_q, irq_q, tx_req_q, tx_remote_q;
	logic [OBJ_IDX_W-1:0] tx_obj_q;

	// ==========================================================
	// Write decode
	wire logic wr_go = aw_full_q & w_full_q & ~bvalid_q;
	wire logic w_obj = (awaddr_q[7:4] == OBJ_BASE_OFS[7:4]);
	wire logic [OBJ_IDX_W-1:0] w_idx = awaddr_q[3:2];
	wire logic w_dir = reg_hit(awaddr_q, DIR_OFS);
	wire logic w_pin = reg_hit(awaddr_q, PIN_CONNECT_OFS);
	wire logic w_stat = reg_hit(awaddr_q, IRQ_STATUS_OFS);
	wire logic w_mask = reg_hit(awaddr_q, IRQ_MASK_OFS);
	wire logic w_line = reg_hit(awaddr_q, LINE_STATE_OFS);
	wire logic w_hit = w_obj | w_dir | w_pin | w_stat | w_mask | w_line;
	wire logic lane0 = wr_go & wstrb_q[0];
	// Unwritten byte lanes read as pair 00, which leaves those flags as they are
	wire logic [15:0] obj_wdata = {wstrb_q[1] ? wdata_q[15:8] : 8'h00,
		wstrb_q[0] ? wdata_q[7:0] : 8'h00}; // [R1]

	// ==========================================================
	// Message objects
	logic [15:0] ctrl_w [NUM_OBJ];
	logic [NUM_OBJ-1:0] want_w, rx_irq_w, tx_irq_w;
	// Transfers stop while the init flag is set
	wire logic rx_ok = rx_frame_i & ~init_q; // [R18]
	wire logic txd_ok = tx_done_i & ~init_q; // [R18]

	for (genvar g = 0; g < NUM_OBJ; g++) begin : g_obj
		cmo_msg_obj u_obj (
			.ref_clk_i(ref_clk_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.dir_tx_i(dir_q[g]),
			.wr_i(wr_go & w_obj & (w_idx == OBJ_IDX_W'(g))),
			.wr_data_i(obj_wdata),
			.rx_data_i(rx_ok & ~rx_remote_i & (rx_obj_i == OBJ_IDX_W'(g))),
			.rx_remote_i(rx_ok & rx_remote_i & (rx_obj_i == OBJ_IDX_W'(g))),
			.tx_done_i(txd_ok & (tx_done_obj_i == OBJ_IDX_W'(g))),
			.ctrl_o(ctrl_w[g]),
			.tx_want_o(want_w[g]),
			.rx_irq_o(rx_irq_w[g]),
			.tx_irq_o(tx_irq_w[g])
		);
	end

	// ==========================================================
	// Transmit arbitration: lowest object index first
	logic [OBJ_IDX_W-1:0] pick;
	always_comb begin
		pick = '0;
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (want_w[i]) begin
				pick = OBJ_IDX_W'(i);
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_req_q <= 1'b0;
			tx_obj_q <= '0;
			tx_remote_q <= 1'b0;
		end else if (ce_i) begin
			tx_req_q <= ~init_q & (|want_w); // [R4] [R18]
			tx_obj_q <= pick;
			tx_remote_q <= ~dir_q[pick];
		end
	end

	// ==========================================================
	// Interrupt status, mask and line
	wire logic [2*NUM_OBJ-1:0] irq_ev = {tx_irq_w, rx_irq_w};
	wire logic [2*NUM_OBJ-1:0] w1c = (lane0 & w_stat) ? wdata_q[2*NUM_OBJ-1:0] : '0;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			stat_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else if (ce_i) begin
			stat_q <= (stat_q & ~w1c) | irq_ev;
			if (lane0 & w_mask) begin
				mask_q <= wdata_q[2*NUM_OBJ-1:0];
			end
			irq_q <= |(stat_q & mask_q);
		end
	end

	// ==========================================================
	// Direction and pin connect registers
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dir_q <= '0;
			psel_q <= PSEL_RST; // [R14]
			init_q <= INIT_RST;
		end else if (ce_i) begin
			if (lane0 & w_dir) begin
				dir_q <= wdata_q[NUM_OBJ-1:0];
			end
			if (lane0 & w_pin) begin
				psel_q <= wdata_q[PSEL_POS+:3];
				init_q <= wdata_q[INIT_POS];
			end
		end
	end

	// ==========================================================
	// Pin routing
	// Reserved codes fall through to the disconnected behaviour as a safe default
	wire logic sel_p0 = (psel_q == PIN_PAIR0); // [R12]
	wire logic sel_p1 = (psel_q == PIN_PAIR1); // [R12]
	wire logic [3:0] tx_mask = sel_p0 ? TX_MASK0 : (sel_p1 ? TX_MASK1 : 4'h0);
	wire logic [3:0] rx_mask = sel_p0 ? RX_MASK0 : (sel_p1 ? RX_MASK1 : 4'h0);
	wire logic tx_line = init_q ? RECESSIVE : bus_transmit_line_i; // [R18] [R11]
	wire logic rx_line_d = sel_p0 ? pin_s2_q[RX_PIN0]
		: (sel_p1 ? pin_s2_q[RX_PIN1] : RECESSIVE); // [R14] [R11]
	wire logic [3:0] pin_out_d = (alt_out_i & ~(tx_mask | rx_mask))
		| (tx_mask & {4{tx_line}}) | (rx_mask & {4{RECESSIVE}}); // [R17]
	// Direction setting has no say over the assigned transmit pin
	wire logic [3:0] pin_oe_n_d = ~port_dir_i & ~tx_mask; // [R15]

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pin_s1_q <= {PIN_W{RECESSIVE}};
			pin_s2_q <= {PIN_W{RECESSIVE}};
			rx_line_q <= RECESSIVE;
			pin_out_q <= '0;
			pin_oe_n_q <= 4'hF;
		end else if (ce_i) begin
			pin_s1_q <= pin_in_i;
			pin_s2_q <= pin_s1_q;
			rx_line_q <= rx_line_d;
			pin_out_q <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
		end
	end

	// ==========================================================
	// AXI4-Lite write channels
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
			awaddr_q <= '0;
		end else if (ce_i) begin
			if (s_axi_awvalid_i & awready_q) begin
				awaddr_q <= s_axi_awaddr_i;
				aw_full_q <= 1'b1;
				awready_q <= 1'b0;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end else if (bvalid_q & s_axi_bready_i) begin
				awready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wready_q <= 1'b1;
			w_full_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (ce_i) begin
			if (s_axi_wvalid_i & wready_q) begin
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
				w_full_q <= 1'b1;
				wready_q <= 1'b0;
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end else if (bvalid_q & s_axi_bready_i) begin
				wready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (ce_i) begin
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q & s_axi_bready_i) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channels
	wire logic [7:0] ra = s_axi_araddr_i;
	wire logic r_obj = (ra[7:4] == OBJ_BASE_OFS[7:4]);
	wire logic r_hit = r_obj | reg_hit(ra, DIR_OFS) | reg_hit(ra, PIN_CONNECT_OFS)
		| reg_hit(ra, IRQ_STATUS_OFS) | reg_hit(ra, IRQ_MASK_OFS) | reg_hit(ra, LINE_STATE_OFS);
	wire logic [31:0] rd_pin = {27'h0, init_q, 1'b0, psel_q};
	wire logic [31:0] rd_w = r_obj ? {16'h0, ctrl_w[ra[3:2]]}
		: reg_hit(ra, DIR_OFS) ? {28'h0, dir_q}
		: reg_hit(ra, PIN_CONNECT_OFS) ? rd_pin
		: reg_hit(ra, IRQ_STATUS_OFS) ? {24'h0, stat_q}
		: reg_hit(ra, IRQ_MASK_OFS) ? {24'h0, mask_q}
		: reg_hit(ra, LINE_STATE_OFS) ? {30'h0, tx_line, rx_line_q}
		: 32'h0;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid_i & arready_q) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_w;
				rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q & s_axi_rready_i) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o = wready_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;
	assign bus_receive_line_o = rx_line_q;
	assign tx_request_o = tx_req_q;
	assign tx_obj_o = tx_obj_q;
	assign tx_remote_o = tx_remote_q;
	assign init_o = init_q;
	assign pin_out_o = pin_out_q;
	assign pin_oe_n_o = pin_oe_n_q;
	assign irq_o = irq_q;

endmodule

//--- shared/cmo_pkg.sv
// Constants, register map and flag helpers for the CAN message-object port link
package cmo_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_OBJ = 4;
	localparam int OBJ_IDX_W = 2;
	localparam int ADDR_W = 8;
	localparam int PIN_W = 4;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OBJ_BASE_OFS = 8'h00;
	localparam logic [7:0] DIR_OFS = 8'h10;
	localparam logic [7:0] PIN_CONNECT_OFS = 8'h14;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h18;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;
	localparam logic [7:0] LINE_STATE_OFS = 8'h20;

	// ==========================================================
	// Message-object control word: low bit of each two-bit flag pair
	localparam int RMT_POS = 14;
	localparam int TRANSMIT_REQUEST_POS = 12;
	localparam int UPD_POS = 10;
	localparam int NEW_POS = 8;
	localparam int VAL_POS = 6;
	localparam int TRANSMIT_IRQ_ENABLE_POS = 4;
	localparam int RECEIVE_IRQ_ENABLE_POS = 2;
	localparam int INT_POS = 0;
	localparam logic [1:0] FLAG_SET = 2'h2;
	localparam logic [1:0] FLAG_RST = 2'h1;
	localparam logic FLAG_RST_VAL = 1'b0;

	// ==========================================================
	// Pin connect register fields and reset values
	localparam int PSEL_POS = 0;
	localparam int INIT_POS = 4;
	localparam logic [2:0] PIN_PAIR0 = 3'h2;
	localparam logic [2:0] PIN_PAIR1 = 3'h3;
	localparam logic [2:0] PIN_NONE = 3'h7;
	localparam logic [2:0] PSEL_RST = PIN_NONE;
	localparam logic INIT_RST = 1'b1;
	localparam logic [3:0] RX_MASK0 = 4'h1;
	localparam logic [3:0] TX_MASK0 = 4'h2;
	localparam logic [3:0] RX_MASK1 = 4'h4;
	localparam logic [3:0] TX_MASK1 = 4'h8;
	localparam int RX_PIN0 = 0;
	localparam int RX_PIN1 = 2;

	// ==========================================================
	// Bus levels and bus answers
	localparam logic DOMINANT = 1'b0;
	localparam logic RECESSIVE = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Helpers
	// Set wins over every clear, so no event is lost to a clear in the same cycle
	function automatic logic flag_next(input logic cur, input logic [1:0] pair, input logic wr,
		input logic hw_set, input logic hw_clr);
		flag_next = hw_set | (wr & (pair == FLAG_SET))
			| (cur & ~(wr & (pair == FLAG_RST)) & ~hw_clr);
	endfunction

	function automatic logic [1:0] flag_rd(input logic b);
		flag_rd = b ? FLAG_SET : FLAG_RST;
	endfunction

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		reg_hit = (addr[7:2] == ofs[7:2]);
	endfunction

endpackage

//--- logic/cmo_msg_obj.sv
// One message object: two-bit flag control word and its hardware events
`timescale 1ns/10ps
module cmo_msg_obj
	import cmo_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic dir_tx_i,
	input wire logic wr_i,
	input wire logic [15:0] wr_data_i,
	input wire logic rx_data_i,
	input wire logic rx_remote_i,
	input wire logic tx_done_i,
	output logic [15:0] ctrl_o,
	output logic tx_want_o,
	output logic rx_irq_o,
	output logic tx_irq_o
);

	logic rmt_q, transmit_request_q, upd_q, new_q, val_q, transmit_irq_enable_q, receive_irq_enable_q, int_q;
	logic rmt_d, transmit_request_d, upd_d, new_d, val_d, transmit_irq_enable_d, receive_irq_enable_d, int_d;
	wire logic rxd = rx_data_i & val_q & ~dir_tx_i;
	wire logic rxr = rx_remote_i & val_q & dir_tx_i;
	wire logic txd = tx_done_i & val_q;

	// ==========================================================
	// Flag updates
	assign rmt_d = flag_next(rmt_q, wr_data_i[RMT_POS+:2], wr_i, rxr, txd & dir_tx_i); // [R2]
	assign transmit_request_d = flag_next(transmit_request_q, wr_data_i[TRANSMIT_REQUEST_POS+:2], wr_i, rxr, txd | rxd); // [R2] [R9]
	// Pair 11-10 holds message lost in a receive object [R10]
	assign upd_d = flag_next(upd_q, wr_data_i[UPD_POS+:2], wr_i, rxd & new_q, 1'b0); // [R10]
	assign new_d = flag_next(new_q, wr_data_i[NEW_POS+:2], wr_i, rxd, txd & dir_tx_i); // [R6]
	assign val_d = flag_next(val_q, wr_data_i[VAL_POS+:2], wr_i, 1'b0, 1'b0); // [R1]
	assign transmit_irq_enable_d = flag_next(transmit_irq_enable_q, wr_data_i[TRANSMIT_IRQ_ENABLE_POS+:2], wr_i, 1'b0, 1'b0); // [R1]
	assign receive_irq_enable_d = flag_next(receive_irq_enable_q, wr_data_i[RECEIVE_IRQ_ENABLE_POS+:2], wr_i, 1'b0, 1'b0); // [R1]
	assign int_d = flag_next(int_q, wr_data_i[INT_POS+:2], wr_i,
		rxd | (txd & dir_tx_i & transmit_irq_enable_q), 1'b0); // [R6]

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			{rmt_q, transmit_request_q, upd_q, new_q} <= {4{FLAG_RST_VAL}};
			{val_q, transmit_irq_enable_q, receive_irq_enable_q, int_q} <= {4{FLAG_RST_VAL}};
		end else if (ce_i) begin
			{rmt_q, transmit_request_q, upd_q, new_q} <= {rmt_d, transmit_request_d, upd_d, new_d};
			{val_q, transmit_irq_enable_q, receive_irq_enable_q, int_q} <= {val_d, transmit_irq_enable_d, receive_irq_enable_d, int_d};
		end
	end

	// ==========================================================
	// Outputs
	// Held while an update is marked ongoing, so a half-written frame never goes out
	assign tx_want_o = val_q & transmit_request_q & (~dir_tx_i | (~upd_q & new_q)); // [R4]
	assign rx_irq_o = rxd & receive_irq_enable_q; // [R6]
	assign tx_irq_o = txd & dir_tx_i & transmit_irq_enable_q;
	assign ctrl_o = {flag_rd(rmt_q), flag_rd(transmit_request_q), flag_rd(upd_q), flag_rd(new_q),
		flag_rd(val_q), flag_rd(transmit_irq_enable_q), flag_rd(receive_irq_enable_q), flag_rd(int_q)}; // [R1]

endmodule

//--- verification/cmo_xcvr_model.sv
// Transceiver and remote node model: one wired-AND bus per pin pair
`timescale 1ns/10ps
module cmo_xcvr_model (
	input wire logic [3:0] pin_out_i,
	input wire logic [3:0] pin_oe_n_i,
	input wire logic remote_tx_i,
	output logic [3:0] pin_in_o
);
	// ==========================================================
	// Bus levels
	logic tx0_w;
	logic tx1_w;
	// Undriven transmit pins float to recessive through the pull-up
	assign tx0_w = pin_oe_n_i[1] | pin_out_i[1];
	assign tx1_w = pin_oe_n_i[3] | pin_out_i[3];
	// Dominant 0 from either node wins the bus
	assign pin_in_o = {tx1_w, remote_tx_i & tx1_w, tx0_w, remote_tx_i & tx0_w};
endmodule

//--- verification/cmo_can_port_link_chk.sv
// Assertion checker for pins, init and register bus of the port link
`timescale 1ns/10ps
module cmo_can_port_link_chk (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic bus_transmit_line_i,
	input wire logic bus_receive_line_o,
	input wire logic tx_request_o,
	input wire logic init_o,
	input wire logic [3:0] pin_out_o,
	input wire logic [3:0] pin_oe_n_o,
	input wire logic [3:0] port_dir_i,
	input wire logic [3:0] alt_out_i
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Unassigned pins may be driven by the port itself, so those cases are excused
	AST_ONE_TX_PIN: assert property (!pin_oe_n_o[1] && !pin_oe_n_o[3] |->
		$past(port_dir_i[1]) || $past(port_dir_i[3])) else $error("both transmit pins driven");
	AST_RX_PIN_HIGH: assert property (
		(pin_oe_n_o[1] || $past(port_dir_i[1]) || pin_out_o[0]) &&
		(pin_oe_n_o[3] || $past(port_dir_i[3]) || pin_out_o[2]))
		else $error("assigned receive pin not high");
	AST_INIT_TX_REC: assert property (init_o && $past(init_o) |->
		(pin_oe_n_o[1] || pin_out_o[1] || !$past(alt_out_i[1])) &&
		(pin_oe_n_o[3] || pin_out_o[3] || !$past(alt_out_i[3])))
		else $error("transmit pin dominant during init");
	AST_INIT_NO_REQ: assert property (init_o && $past(init_o) |-> !tx_request_o)
		else $error("transmit request during init");
	AST_IDLE_RECV: assert property ((pin_oe_n_o[1] && pin_oe_n_o[3]) [*3] |->
		bus_receive_line_o) else $error("receive not recessive without pins");
	AST_TX_FOLLOW0: assert property ((!init_o && !pin_oe_n_o[1] &&
		!$past(port_dir_i[1]) && $stable(bus_transmit_line_i)) [*3] |->
		pin_out_o[1] == bus_transmit_line_i) else $error("first transmit pin wrong level");
	AST_TX_FOLLOW1: assert property ((!init_o && !pin_oe_n_o[3] &&
		!$past(port_dir_i[3]) && $stable(bus_transmit_line_i)) [*3] |->
		pin_out_o[3] == bus_transmit_line_i) else $error("second transmit pin wrong level");
	AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
	AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
endmodule

bind cmo_can_port_link cmo_can_port_link_chk u_chk (.ref_clk_i, .rst_i, .s_axi_bvalid_o,
	.s_axi_bready_i, .s_axi_bresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
	.bus_transmit_line_i, .bus_receive_line_o, .tx_request_o, .init_o, .pin_out_o, .pin_oe_n_o,
	.port_dir_i, .alt_out_i);

//--- verification/test_cmo_can_port_link.sv
// Self-checking testbench of the CAN port link
`timescale 1ns/10ps
module test_cmo_can_port_link;
	import cmo_pkg::*;
	// ==========================================================
	// Signals
	logic ref_clk_i, rst_i, ce_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic s_axi_arvalid_i, s_axi_rready_i, rx_frame_i, rx_remote_i, tx_done_i;
	logic bus_transmit_line_i, remote_tx, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_arready_o, s_axi_rvalid_o, bus_receive_line_o, tx_request_o, tx_remote_o;
	logic init_o, irq_o;
	logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, r;
	logic [3:0] s_axi_wstrb_i, port_dir_i, alt_out_i, pin_in_i, pin_out_o, pin_oe_n_o;
	logic [1:0] rx_obj_i, tx_done_obj_i, tx_obj_o, s_axi_bresp_o, s_axi_rresp_o;
	// Only the documented pin codes are ever written
	logic [2:0] codes [4] = '{3'h2, 3'h3, 3'h7, 3'h2};
	int errors, checks, cycles, idx;
	integer seed = 32'h0178475D;

	cmo_can_port_link u_dut (.ref_clk_i, .rst_i, .ce_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.rx_frame_i, .rx_remote_i, .rx_obj_i, .tx_done_i, .tx_done_obj_i, .bus_transmit_line_i,
		.bus_receive_line_o, .tx_request_o, .tx_obj_o, .tx_remote_o, .init_o, .port_dir_i,
		.alt_out_i, .pin_in_i, .pin_out_o, .pin_oe_n_o, .irq_o);
	cmo_xcvr_model u_xcvr (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
		.remote_tx_i(remote_tx), .pin_in_o(pin_in_i));

	// ==========================================================
	// Clock and hang guard
	always #12.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			conclude();
		end
	end

	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk1(input logic seen, input logic exp);
		check({31'h0, seen}, {31'h0, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		while (!(aw && w)) begin
			@(posedge ref_clk_i);
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		// Late ready makes the slave hold its answer for a while
		tick(2);
		s_axi_bready_i <= 1'b1;
		do @(posedge ref_clk_i); while (s_axi_bvalid_o !== 1'b1);
		s_axi_bready_i <= 1'b0;
		check({30'h0, s_axi_bresp_o}, {30'h0, RESP_OKAY});
		@(posedge ref_clk_i);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do @(posedge ref_clk_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		@(posedge ref_clk_i);
		s_axi_rready_i <= 1'b1;
		do @(posedge ref_clk_i); while (s_axi_rvalid_o !== 1'b1);
		s_axi_rready_i <= 1'b0;
		check(s_axi_rdata_o, exp);
		check({30'h0, s_axi_rresp_o}, {30'h0, er});
		@(posedge ref_clk_i);
	endtask
	task automatic pulse(input logic rx, input logic rem, input logic [1:0] obj);
		rx_frame_i <= rx;
		tx_done_i <= ~rx;
		rx_remote_i <= rem;
		rx_obj_i <= obj;
		tx_done_obj_i <= obj;
		@(posedge ref_clk_i);
		rx_frame_i <= 1'b0;
		tx_done_i <= 1'b0;
		tick(3);
	endtask
	function automatic logic exp_rx(input logic [2:0] sel, input logic tx, input logic rem);
		exp_rx = (sel == PIN_PAIR0 || sel == PIN_PAIR1) ? (tx & rem) : RECESSIVE;
	endfunction
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		ref_clk_i = 1'b0;
		{rst_i, ce_i, s_axi_wstrb_i} <= 6'h3F;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} <= 4'h0;
		{s_axi_rready_i, rx_frame_i, rx_remote_i, tx_done_i, remote_tx} <= 5'h1;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= 48'h0;
		{rx_obj_i, tx_done_obj_i, bus_transmit_line_i} <= 5'h1;
		{port_dir_i, alt_out_i} <= 8'h0;
		tick(8);
		rst_i <= 1'b0;
		tick(1);
		axi_rd(OBJ_BASE_OFS, 32'h5555, RESP_OKAY);
		axi_rd(PIN_CONNECT_OFS, 32'h17, RESP_OKAY);
		chk1(bus_receive_line_o, RECESSIVE);
		axi_rd(8'hFC, 32'h0, RESP_SLVERR);
		// Transmit object answers a remote frame only after the update ends
		axi_wr(DIR_OFS, 32'h1);
		axi_wr(PIN_CONNECT_OFS, 32'h2);
		axi_wr(OBJ_BASE_OFS, 32'h5995);
		pulse(1'b1, 1'b1, 2'h0);
		axi_rd(OBJ_BASE_OFS, 32'hA995, RESP_OKAY);
		chk1(tx_request_o, 1'b0);
		axi_wr(OBJ_BASE_OFS, 32'h0600);
		tick(2);
		check({28'h0, tx_request_o, tx_remote_o, tx_obj_o}, 32'h8);
		pulse(1'b0, 1'b0, 2'h0);
		chk1(tx_request_o, 1'b0);
		// Receive object: remote request, data, loss and interrupt
		axi_wr(IRQ_MASK_OFS, 32'h2);
		axi_wr(8'h04, 32'h5599);
		axi_wr(8'h04, 32'h2000);
		tick(2);
		check({28'h0, tx_request_o, tx_remote_o, tx_obj_o}, 32'hD);
		pulse(1'b1, 1'b0, 2'h1);
		axi_rd(8'h04, 32'h569A, RESP_OKAY);
		chk1(irq_o, 1'b1);
		pulse(1'b1, 1'b0, 2'h1);
		axi_rd(8'h04, 32'h5A9A, RESP_OKAY);
		for (idx = 0; idx < 2; idx++) begin
			axi_wr(IRQ_MASK_OFS, {30'h0, idx[0], 1'b0});
			tick(2);
			chk1(irq_o, idx[0]);
		end
		axi_rd(IRQ_STATUS_OFS, 32'h2, RESP_OKAY);
		axi_wr(IRQ_STATUS_OFS, 32'h2);
		tick(2);
		chk1(irq_o, 1'b0);
		axi_wr(8'h04, 32'h0101);
		axi_rd(8'h04, 32'h5999, RESP_OKAY);
		// A frame offered while the clock enable is low must leave no trace
		ce_i <= 1'b0;
		pulse(1'b1, 1'b0, 2'h1);
		ce_i <= 1'b1;
		axi_rd(8'h04, 32'h5999, RESP_OKAY);
		// Pin routing with random line levels, alternate outputs and directions
		for (idx = 0; idx < 4; idx++) begin
			axi_wr(PIN_CONNECT_OFS, {29'h0, codes[idx]});
			repeat (4) begin
				r = $random(seed);
				bus_transmit_line_i <= r[0];
				remote_tx <= r[1];
				port_dir_i <= r[7:4] & 4'hA;
				alt_out_i <= r[11:8];
				tick(6);
				chk1(bus_receive_line_o, exp_rx(codes[idx], r[0], r[1]));
				if (codes[idx] == PIN_PAIR0 || codes[idx] == PIN_PAIR1) begin
					check({30'h0, pin_oe_n_o[codes[idx][0] * 2 + 1],
						pin_out_o[codes[idx][0] * 2 + 1]}, {31'h0, r[0]});
				end
			end
		end
		// Init stops events and forces the transmit pin recessive
		axi_wr(PIN_CONNECT_OFS, 32'h12);
		bus_transmit_line_i <= DOMINANT;
		tick(4);
		chk1(pin_out_o[1], RECESSIVE);
		chk1(init_o, 1'b1);
		pulse(1'b1, 1'b0, 2'h1);
		axi_rd(8'h04, 32'h5999, RESP_OKAY);
		axi_rd(LINE_STATE_OFS, {30'h0, RECESSIVE, remote_tx}, RESP_OKAY);
		conclude();
	end
endmodule
